// ### logic/fdmw_regs.svh
// Purpose: Constants for the host controller of the flash disk memory window.
// Assumes: Included by bare name; holds definitions only.
// Notes: Window offsets are relative to the window base chosen by the host.
// Contract
// - Host addresses window with 13 address bits.
// - Chip select and strobes are active low.
// - Write only while select and write strobe.
// - Read only while select and output strobe.
// - Mode changes by control write or detector.
// - Offsets relative to host chosen window base.
`ifndef FDMW_REGS_SVH
`define FDMW_REGS_SVH
`define FDMW_ADDR_W 13
`define FDMW_DATA_W 8
`define FDMW_SECT_HI 12
`define FDMW_SECT_LO 11
`define FDMW_SECT_BOOT0 2'h0
`define FDMW_SECT_DATA 2'h1
`define FDMW_SECT_CTRL 2'h2
`define FDMW_SECT_BOOT1 2'h3
`define FDMW_BOOT_MASK 13'h01ff
`define FDMW_RESET_READ 8'h00
`define FDMW_SETUP_CYC 4'h2
`define FDMW_STROBE_CYC 4'h8
`define FDMW_HOLD_CYC 4'h2
`endif

// ### logic/fdmw_pkg.sv
// Purpose: Types for the flash disk memory window host controller.
// Assumes: Nothing beyond the constants header.
// Notes: None.
`default_nettype none
package fdmw_pkg;
   typedef enum logic [1:0] {
      FDMW_SECT_BOOT_LO,
      FDMW_SECT_FLASH,
      FDMW_SECT_REGS,
      FDMW_SECT_BOOT_HI
   } fdmw_sect_e;
endpackage
`default_nettype wire

// ### logic/fdmw_fifo.sv
// Purpose: Synchronous FIFO buffering read data toward the user.
// Assumes: One clock; asynchronous active high reset.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/1ps
`default_nettype none
module fdmw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Handshake terms from the occupancy count.
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   // Storage array write port.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // fdmw_fifo
`default_nettype wire

// ### logic/fdmw_host.sv
// Purpose: Host side controller driving the flash disk memory window pins.
// Assumes: Device has no clock, so timing comes from counted sys_clk cycles.
// Notes: Read data is pushed into a FIFO; a byte held back by a full FIFO stalls all new requests.
// Notes: Phase lengths are parameters; each must be at least one cycle.
// Notes: Only the 13 window offset bits leave the block; the base is the host's.
`timescale 1ns/1ps
`default_nettype none
`include "fdmw_regs.svh"
module fdmw_host
   import fdmw_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter logic [3:0] SETUP_CYC = `FDMW_SETUP_CYC,
   parameter logic [3:0] STROBE_CYC = `FDMW_STROBE_CYC,
   parameter logic [3:0] HOLD_CYC = `FDMW_HOLD_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [`FDMW_ADDR_W-1:0] req_addr,
   input wire logic [`FDMW_DATA_W-1:0] req_wdata,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [`FDMW_DATA_W-1:0] rd_data,
   output logic req_section_q_boot,
   output logic [`FDMW_ADDR_W-1:0] win_addr_q,
   output logic chip_sel_n_q,
   output logic out_strobe_n_q,
   output logic wr_strobe_n_q,
   input wire logic [`FDMW_DATA_W-1:0] win_data_in,
   output logic [`FDMW_DATA_W-1:0] win_data_out_q,
   output logic win_data_oe_q
);
   // -----------------------------------------------------------------
   // Cycle sequencer
   // -----------------------------------------------------------------
   // Timing of one transfer, counted in sys_clk edges from the edge that takes
   // the request (edge 0), with the default phase lengths:
   //    edge 0       request taken; address, write data and direction latched.
   //    edge 0 out   chip select falls; a write also turns the data drivers on.
   //    edge 2 out   the read or write strobe falls after the setup phase.
   //    edge 10 out  the strobe rises after eight cycles low.
   //    edge 12 out  chip select rises and the write drivers turn off.
   // For a read, the bus value sampled at edge 10, the last edge with the strobe
   // still low, leaves the synchroniser at edge 12 and is captured there; it
   // enters the FIFO at edge 13 and is offered to the user from then on.
   // The device has no clock of its own, so everything it does is triggered by
   // these pin edges; the phase counts are the only timing the host can give.
   // Hazard: read data must be valid at the pins by the edge that raises the
   // strobe, because the synchroniser delays what is captured by two cycles.
   // A write lands in the device when the write strobe rises while chip select
   // is still low, which the hold phase guarantees.
   // The next request can be taken at edge 13 after a write, and at edge 14 after a read, once the captured byte has entered the FIFO.
   // Limitation: there is no overlap between transfers; one byte moves at a time.
   // A read whose byte cannot enter a full FIFO blocks every later request
   // until the user drains the FIFO, so no byte is ever dropped.
   typedef enum logic [1:0] {
      FDMW_IDLE,
      FDMW_SETUP,
      FDMW_STROBE,
      FDMW_HOLD
   } fdmw_state_e;

   fdmw_state_e state_q;
   logic [3:0] cnt_q;
   logic write_q;
   logic [`FDMW_DATA_W-1:0] sync1_q;
   logic [`FDMW_DATA_W-1:0] sync2_q;
   logic [`FDMW_DATA_W-1:0] cap_q;
   logic cap_valid_q;
   logic fifo_in_ready;
   logic take;
   fdmw_sect_e sect;
   logic sect_boot;

   // A new request is taken only when idle and no captured byte waits.
   assign req_ready = (state_q == FDMW_IDLE) && !cap_valid_q;
   assign take = req_valid && req_ready;
   // Section decode of the requested offset, relative to window base.
   assign sect = fdmw_sect_e'(req_addr[`FDMW_SECT_HI:`FDMW_SECT_LO]);

   // Section of the requested offset; both boot sections show one 512 byte area.
   always_comb begin
      unique case (sect)
         FDMW_SECT_BOOT_LO: sect_boot = 1'b1;
         FDMW_SECT_FLASH: sect_boot = 1'b0;
         FDMW_SECT_REGS: sect_boot = 1'b0;
         FDMW_SECT_BOOT_HI: sect_boot = 1'b1;
      endcase
   end

   // State and phase counter.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= FDMW_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            FDMW_IDLE: begin
               if (take) begin
                  state_q <= FDMW_SETUP;
                  cnt_q <= SETUP_CYC;
               end
            end
            FDMW_SETUP: begin
               if (cnt_q <= 4'h1) begin
                  state_q <= FDMW_STROBE;
                  cnt_q <= STROBE_CYC;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            FDMW_STROBE: begin
               if (cnt_q <= 4'h1) begin
                  state_q <= FDMW_HOLD;
                  cnt_q <= HOLD_CYC;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            FDMW_HOLD: begin
               if (cnt_q <= 4'h1) begin
                  state_q <= FDMW_IDLE;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   // Address, write data and direction latched on acceptance.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         win_addr_q <= '0;
         win_data_out_q <= '0;
         write_q <= 1'b0;
         req_section_q_boot <= 1'b0;
      end else if (take) begin
         win_addr_q <= req_addr;
         win_data_out_q <= req_wdata;
         write_q <= req_write;
         req_section_q_boot <= sect_boot;
      end
   end

   // Active low strobes; select spans setup to hold, strobe only its phase.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chip_sel_n_q <= 1'b1;
         out_strobe_n_q <= 1'b1;
         wr_strobe_n_q <= 1'b1;
         win_data_oe_q <= 1'b0;
      end else begin
         chip_sel_n_q <= !(take || (state_q != FDMW_IDLE &&
                           !(state_q == FDMW_HOLD && cnt_q <= 4'h1)));
         out_strobe_n_q <= !(((state_q == FDMW_SETUP && cnt_q <= 4'h1) ||
                             (state_q == FDMW_STROBE && cnt_q > 4'h1)) && !write_q);
         // A mode change is an ordinary complete write, so it needs no special case.
         wr_strobe_n_q <= !(((state_q == FDMW_SETUP && cnt_q <= 4'h1) ||
                            (state_q == FDMW_STROBE && cnt_q > 4'h1)) && write_q);
         // Host drives data only for writes, never while the device may.
         win_data_oe_q <= (take && req_write) ||
                          (write_q && state_q != FDMW_IDLE &&
                           !(state_q == FDMW_HOLD && cnt_q <= 4'h1));
      end
   end

   // -----------------------------------------------------------------
   // Read capture
   // -----------------------------------------------------------------
   // Two stage synchroniser on the data pins.
   // The device answers with no clock, so its data is asynchronous to sys_clk.
   // Only the second stage is read; the first may still be settling.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= win_data_in;
         sync2_q <= sync1_q;
      end
   end

   // Capture at the end of the hold phase, after data had time to settle.
   // A new capture and a FIFO acceptance never meet, since the capture only
   // happens while a read is in flight and a pending byte blocks new requests.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cap_q <= `FDMW_RESET_READ;
         cap_valid_q <= 1'b0;
      end else begin
         if (state_q == FDMW_HOLD && cnt_q <= 4'h1 && !write_q) begin
            cap_q <= sync2_q;
            cap_valid_q <= 1'b1;
         end else if (cap_valid_q && fifo_in_ready) begin
            cap_valid_q <= 1'b0;
         end
      end
   end

   // Read data buffer toward the user.
   // It lets the user drain bytes at its own pace while the pins keep moving.
   // Bytes leave in the order in which the reads were issued.
   fdmw_fifo #(
      .WIDTH(`FDMW_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(cap_valid_q),
      .in_ready(fifo_in_ready),
      .in_data(cap_q),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );
endmodule // fdmw_host
`default_nettype wire

// ### test/fdmw_host_props.sv
// Purpose: Assertions on the window pins of the host controller.
// Assumes: Bound to fdmw_host; one clock domain.
// Notes: Strobe width is counted in helper logic.
`timescale 1ns/1ps
`default_nettype none
`include "fdmw_regs.svh"
module fdmw_props
   import fdmw_pkg::*;
#(
   parameter logic [3:0] STROBE_CYC = `FDMW_STROBE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [`FDMW_ADDR_W-1:0] win_addr_q,
   input wire logic chip_sel_n_q,
   input wire logic out_strobe_n_q,
   input wire logic wr_strobe_n_q,
   input wire logic win_data_oe_q
);
   logic [4:0] low_cnt_q;
   // Counts the cycles for which a strobe is held low.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         low_cnt_q <= 5'h00;
      end else begin
         low_cnt_q <= (out_strobe_n_q && wr_strobe_n_q) ? 5'h00 : low_cnt_q + 5'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_write_has_select: assert property (!wr_strobe_n_q |-> !chip_sel_n_q)
      else $error("write strobe without select");
   a_read_has_select: assert property (!out_strobe_n_q |-> !chip_sel_n_q)
      else $error("read strobe without select");
   a_strobes_apart: assert property (out_strobe_n_q || wr_strobe_n_q)
      else $error("both strobes low");
   a_drive_not_read: assert property (win_data_oe_q |-> out_strobe_n_q)
      else $error("host drives data in a read");
   a_strobe_width: assert property ($rose(out_strobe_n_q && wr_strobe_n_q)
      |-> low_cnt_q == 5'(STROBE_CYC))
      else $error("strobe width wrong");
   a_setup_select: assert property ($fell(out_strobe_n_q && wr_strobe_n_q)
      |-> $past(!chip_sel_n_q, 2))
      else $error("select too late before strobe");
   a_take_selects: assert property (req_valid && req_ready |-> ##[1:2] !chip_sel_n_q)
      else $error("accepted request not started");
   a_addr_held: assert property (!chip_sel_n_q && $past(!chip_sel_n_q)
      |-> $stable(win_addr_q))
      else $error("address moved in a cycle");
endmodule // fdmw_props
bind fdmw_host fdmw_props #(.STROBE_CYC(STROBE_CYC)) u_props (.sys_clk(sys_clk),
   .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .win_addr_q(win_addr_q),
   .chip_sel_n_q(chip_sel_n_q), .out_strobe_n_q(out_strobe_n_q),
   .wr_strobe_n_q(wr_strobe_n_q), .win_data_oe_q(win_data_oe_q));
`default_nettype wire

// ### test/fdmw_dev.sv
// Purpose: Behavioural model of the flash disk window device.
// Assumes: No clock; strobes and the detector input trigger every action.
// Notes: Boot bytes start as index xor 3c.
`timescale 1ns/1ps
`default_nettype none
`include "fdmw_regs.svh"
module fdmw_dev (
   input wire logic [`FDMW_ADDR_W-1:0] addr,
   input wire logic chip_sel_n,
   input wire logic out_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic boot_trig,
   input wire logic [`FDMW_DATA_W-1:0] data_in,
   output logic [`FDMW_DATA_W-1:0] data_out,
   output logic data_oe
);
   logic [7:0] boot_mem [0:511];
   logic [7:0] win_mem [0:4095];
   logic normal_q;
   logic [1:0] sect;
   logic boot_hit;
   logic [8:0] page_cnt;
   logic page_done;
   logic [7:0] status;
   assign sect = addr[12:11];
   assign boot_hit = (sect == `FDMW_SECT_BOOT0) || (sect == `FDMW_SECT_BOOT1);
   // Starts in reset mode with a known boot image.
   initial begin
      normal_q = 1'b0;
      page_cnt = 9'h000;
      page_done = 1'b0;
      for (int i = 0; i < 512; i++) begin
         boot_mem[i] = 8'(i) ^ 8'h3c;
      end
   end
   // Writes land at the rising write strobe; the detector forces normal mode.
   always @(posedge wr_strobe_n or posedge boot_trig) begin
      if (boot_trig) begin
         normal_q <= 1'b1;
      end else if (!chip_sel_n && sect == `FDMW_SECT_CTRL && addr[10:0] == 11'h000) begin
         normal_q <= data_in[0];
      end else if (!chip_sel_n && normal_q && boot_hit) begin
         boot_mem[addr[8:0]] <= data_in;
      end else if (!chip_sel_n && normal_q) begin
         win_mem[addr[11:0]] <= data_in;
         // Counts data window bytes; a full 512 byte page completes a signature.
         if (sect == `FDMW_SECT_DATA) begin
            page_cnt <= page_cnt + 9'h001;
            if (page_cnt == 9'h1ff) begin
               page_done <= 1'b1;
            end
         end
      end
   end
   // Drives the bus only while select and output strobe are both low.
   assign data_oe = !chip_sel_n && !out_strobe_n;
   // Status byte: bit 0 media ready, bit 1 a page signature completed.
   // The code's symbol width and correction strength are not modelled here.
   assign status = {6'h00, page_done, 1'b1};
   assign data_out = boot_hit ? boot_mem[addr[8:0]] :
      !normal_q ? `FDMW_RESET_READ :
      (sect == `FDMW_SECT_CTRL && addr[10:0] == 11'h001) ? status :
      win_mem[addr[11:0]];
endmodule // fdmw_dev
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench of the window host controller.
// Assumes: Device model on the pins; FIFO drained by the bench.
// Notes: Idle data bus shows a toggling pattern.
`timescale 1ns/1ps
`default_nettype none
`include "fdmw_regs.svh"
module tb;
   import fdmw_pkg::*;
   logic sys_clk, reset, req_valid, req_write, rd_ready, boot_trig, req_ready, rd_valid;
   logic cs_n, oe_n, we_n, h_oe, d_oe, sect_boot;
   logic [`FDMW_ADDR_W-1:0] req_addr, win_addr;
   logic [7:0] req_wdata, rd_data, h_do, d_do, win_data_in;
   int error_cnt, num_checks, cyc;
   // Resolves the shared data bus from both drivers' enables.
   assign win_data_in = h_oe ? h_do : d_oe ? d_do : (8'h5a ^ {8{sys_clk}});
   fdmw_host DUT (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .req_section_q_boot(sect_boot), .win_addr_q(win_addr), .chip_sel_n_q(cs_n),
      .out_strobe_n_q(oe_n), .wr_strobe_n_q(we_n), .win_data_in(win_data_in),
      .win_data_out_q(h_do), .win_data_oe_q(h_oe));
   fdmw_dev u_dev (.addr(win_addr), .chip_sel_n(cs_n), .out_strobe_n(oe_n),
      .wr_strobe_n(we_n), .boot_trig(boot_trig), .data_in(win_data_in),
      .data_out(d_do), .data_oe(d_oe));
   //----------------------------------------------------------------
   // Tasks
   //----------------------------------------------------------------
   task automatic complete_run();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s exp=%h got=%h", nm, exp, got);
      end
   endtask
   task automatic send(input logic wr, input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(negedge sys_clk);
      req_valid = 1'b0;
   endtask
   task automatic pop(input string nm, input logic [7:0] exp);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk(nm, exp, rd_valid === 1'b1 ? rd_data : ~exp);
      rd_ready = 1'b1;
      @(negedge sys_clk);
      rd_ready = 1'b0;
      // Lets an edge pass so that a following pop does not raise ready at once.
      @(negedge sys_clk);
   endtask
   task automatic rd(input string nm, input logic [12:0] a, input logic [7:0] exp);
      send(1'b0, a, 8'h00);
      pop(nm, exp);
   endtask
   task automatic t_reset_mode();
      send(1'b1, 13'h0810, 8'h9c);
      rd("reset data", 13'h0810, 8'h00);
      rd("reset ctrl", 13'h1004, 8'h00);
      rd("reset boot", 13'h1805, 8'h39);
   endtask
   task automatic t_normal();
      send(1'b1, 13'h1000, 8'h01);
      send(1'b1, 13'h0810, 8'h9c);
      rd("flash data", 13'h0810, 8'h9c);
      chk("data flag", 8'h00, {7'h00, sect_boot});
      send(1'b1, 13'h0203, 8'h77);
      rd("boot alias", 13'h0603, 8'h77);
      chk("boot flag", 8'h01, {7'h00, sect_boot});
      rd("boot mirror", 13'h1e03, 8'h77);
      send(1'b1, 13'h1000, 8'h00);
      rd("back to reset", 13'h0810, 8'h00);
      boot_trig = 1'b1;
      @(negedge sys_clk);
      boot_trig = 1'b0;
      rd("detector", 13'h0810, 8'h9c);
   endtask
   task automatic t_page();
      rd("status idle", 13'h1001, 8'h01);
      for (int i = 0; i < 512; i++) begin
         send(1'b1, 13'h0800 + 13'(i), 8'(i));
      end
      rd("status page", 13'h1001, 8'h03);
   endtask
   task automatic t_fill();
      for (int i = 0; i < 17; i++) begin
         send(1'b0, 13'h0040 + 13'(i), 8'h00);
      end
      repeat (30) @(negedge sys_clk);
      chk("full refuse", 8'h00, {7'h00, req_ready});
      for (int i = 0; i < 17; i++) begin
         pop("fifo order", (8'h40 + 8'(i)) ^ 8'h3c);
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      {reset, req_valid, req_write, rd_ready, boot_trig} = 5'h10;
      req_addr = 13'h0000;
      req_wdata = 8'h00;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      t_reset_mode();
      t_normal();
      t_page();
      t_fill();
      complete_run();
   end
endmodule // tb
`default_nettype wire
